// ### logic/monitor_fault_status_regs.sv
// Fault flags, resolution, ready status and alert enables of a monitor
//
// Notes on behaviour
// - Over-maximum events set odd fault bits
// - Under-minimum events set even fault bits
// - Fault flags clear to zero at reset
// - Fault register readable and writable by host
// - Resolution bit: one is 8-bit, zero 12-bit
// - Resolution bits six to zero read zero
// - Ready register read-only, cleared by read
// - Bit seven: both current converters ready
// - Bit six voltage ready, low bits name input
// - Bits five to zero map aux and supply inputs
// - Channel-two enables, one per comparison
// - Enables readable, writable, reset disabled
// - Clear-on-read control clears faults on read
`timescale 1ns/1ns
module monitor_fault_status_regs #(
  parameter int DATA_W = monitor_regs_pkg::DATA_W
) (
  input  wire logic                    I_CLK,
  input  wire logic                    I_RST,
  input  wire logic [7:0]              I_ADDR,
  input  wire logic                    I_WR,
  input  wire logic                    I_RD,
  input  wire logic [DATA_W-1:0]       I_WDATA,
  input  wire logic [3:0]              I_CH1_OVER,
  input  wire logic [3:0]              I_CH1_UNDER,
  input  wire logic                    I_CLEAR_ON_READ,
  input  wire logic                    I_CURRENT_CONVERTERS_READY,
  input  wire logic                    I_VOLTAGE_CONVERTER_READY,
  input  wire logic [5:0]              I_VOLTAGE_CONVERTER_INPUT,
  input  wire logic [DATA_W-1:0]       I_CH1_ALERT_EN,
  input  wire logic [DATA_W-1:0]       I_CH2_FAULT,
  output logic      [DATA_W-1:0]       O_RDATA,
  output logic                         O_RES_8BIT,
  output logic      [DATA_W-1:0]       O_CH1_FAULT,
  output logic      [DATA_W-1:0]       O_CH2_ALERT_EN,
  output logic                         O_ALERT
);
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              res_8bit;
    logic [DATA_W-1:0] ch2_alert_en;
    logic              alert;
  } state_t;

  state_t            state_q;
  state_t            state_d;
  logic [DATA_W-1:0] fault_set;
  logic [DATA_W-1:0] fault_q;
  logic [DATA_W-1:0] ready_set;
  logic [DATA_W-1:0] ready_q;
  logic              fault_wr;
  logic              fault_clr;
  logic              ready_clr;

  if (DATA_W != monitor_regs_pkg::DATA_W) begin : g_width_check
    $error("monitor_fault_status_regs: DATA_W must be 8");
  end

  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] target);
    hit = (addr == target);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // Event mapping

  // Event index 3 is power, 0 is aux input one
  for (genvar g = 0; g < monitor_regs_pkg::MEAS_N; g++) begin : g_fault_map
    assign fault_set[2*g+1] = I_CH1_OVER[g];
    assign fault_set[2*g]   = I_CH1_UNDER[g];
  end

  always_comb begin
    ready_set = '0;
    ready_set[monitor_regs_pkg::CURRENT_CONVERTERS_READY_BIT] = I_CURRENT_CONVERTERS_READY;
    ready_set[monitor_regs_pkg::VOLTAGE_CONVERTER_READY_BIT] = I_VOLTAGE_CONVERTER_READY;
    // Input 0..5: supply one, supply two, aux one to four
    ready_set[monitor_regs_pkg::VIN_N-1:0] =
      I_VOLTAGE_CONVERTER_READY ? I_VOLTAGE_CONVERTER_INPUT : 6'h00;
  end

  assign fault_wr  = I_WR && hit(I_ADDR, monitor_regs_pkg::ADDR_CH1_FAULT);
  assign fault_clr = I_RD && I_CLEAR_ON_READ &&
                     hit(I_ADDR, monitor_regs_pkg::ADDR_CH1_FAULT);
  assign ready_clr = I_RD && hit(I_ADDR, monitor_regs_pkg::ADDR_READY);

  ////////////////////////////////////////////////////////////////////////
  // Flag banks

  sticky_flags #(
    .WIDTH     (DATA_W),
    .RST_VALUE (monitor_regs_pkg::RST_CH1_FAULT)
  ) fault_bank (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_set   (fault_set),
    .i_wr    (fault_wr),
    .i_wdata (I_WDATA),
    .i_clr   (fault_clr),
    .o_flags (fault_q)
  );

  sticky_flags #(
    .WIDTH     (DATA_W),
    .RST_VALUE (monitor_regs_pkg::RST_READY)
  ) ready_bank (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_set   (ready_set),
    .i_wr    (1'b0),
    .i_wdata (monitor_regs_pkg::ZERO_BYTE),
    .i_clr   (ready_clr),
    .o_flags (ready_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Registers, read data and alert

  always_comb begin
    state_d = state_q;
    if (I_WR && hit(I_ADDR, monitor_regs_pkg::ADDR_RESOLUTION)) begin
      state_d.res_8bit = I_WDATA[monitor_regs_pkg::RES_BIT];
    end
    if (I_WR && hit(I_ADDR, monitor_regs_pkg::ADDR_CH2_ALERT)) begin
      state_d.ch2_alert_en = I_WDATA;
    end
    if (I_RD) begin
      unique case (I_ADDR)
        monitor_regs_pkg::ADDR_CH1_FAULT: begin
          state_d.rdata = fault_q;
        end
        monitor_regs_pkg::ADDR_RESOLUTION: begin
          state_d.rdata = {state_q.res_8bit, 7'h00};
        end
        monitor_regs_pkg::ADDR_READY: begin
          state_d.rdata = ready_q;
        end
        monitor_regs_pkg::ADDR_CH2_ALERT: begin
          state_d.rdata = state_q.ch2_alert_en;
        end
        default: begin
          state_d.rdata = monitor_regs_pkg::ZERO_BYTE;
        end
      endcase
    end
    state_d.alert = |(fault_q & I_CH1_ALERT_EN) |
                    |(I_CH2_FAULT & state_q.ch2_alert_en);
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_q.rdata        <= monitor_regs_pkg::ZERO_BYTE;
      state_q.res_8bit     <= monitor_regs_pkg::RST_RES_8BIT;
      state_q.ch2_alert_en <= monitor_regs_pkg::RST_CH2_ALERT;
      state_q.alert        <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign O_RDATA        = state_q.rdata;
  assign O_RES_8BIT     = state_q.res_8bit;
  assign O_CH1_FAULT    = fault_q;
  assign O_CH2_ALERT_EN = state_q.ch2_alert_en;
  assign O_ALERT        = state_q.alert;
endmodule : monitor_fault_status_regs

// ### logic/monitor_regs_pkg.sv
// Constants for the fault and status register slice
package monitor_regs_pkg;
  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 8;
  localparam int          MEAS_N          = 4;
  localparam int          VIN_N           = 6;
  localparam logic [7:0]  ADDR_CH1_FAULT  = 8'h03;
  localparam logic [7:0]  ADDR_RESOLUTION = 8'h04;
  localparam logic [7:0]  ADDR_READY      = 8'h32;
  localparam logic [7:0]  ADDR_CH2_ALERT  = 8'h34;
  localparam logic [7:0]  RST_CH1_FAULT   = 8'h00;
  localparam logic [7:0]  RST_READY       = 8'h00;
  localparam logic [7:0]  RST_CH2_ALERT   = 8'h00;
  localparam logic        RST_RES_8BIT    = 1'b0;
  localparam int          RES_BIT         = 7;
  localparam int          CURRENT_CONVERTERS_READY_BIT  = 7;
  localparam int          VOLTAGE_CONVERTER_READY_BIT  = 6;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;
endpackage : monitor_regs_pkg

// ### logic/sticky_flags.sv
// Sticky flag register: hardware sets, host writes or clears
`timescale 1ns/1ns
module sticky_flags #(
  parameter int         WIDTH     = 8,
  parameter logic [7:0] RST_VALUE = 8'h00
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic             i_wr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic             i_clr,
  output logic      [WIDTH-1:0] o_flags
);
  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } state_t;

  state_t state_q;
  state_t state_d;

  if (WIDTH < 1 || WIDTH > 8) begin : g_width_check
    $error("sticky_flags: WIDTH must be 1 to 8");
  end

  always_comb begin
    state_d = state_q;
    if (i_wr) begin
      state_d.flags = i_wdata;
    end
    if (i_clr) begin
      state_d.flags = '0;
    end
    // Set wins over write and clear
    state_d.flags = state_d.flags | i_set;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q.flags <= RST_VALUE[WIDTH-1:0];
    end else begin
      state_q <= state_d;
    end
  end

  assign o_flags = state_q.flags;
endmodule : sticky_flags

// ### testbench/monitor_regs_sva.sv
// Port assertions for the fault and status register slice
`timescale 1ns/1ns
module monitor_regs_sva (
  input wire logic       I_CLK,
  input wire logic       I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic       I_WR,
  input wire logic       I_RD,
  input wire logic [7:0] I_WDATA,
  input wire logic [3:0] I_CH1_OVER,
  input wire logic [3:0] I_CH1_UNDER,
  input wire logic       I_CLEAR_ON_READ,
  input wire logic [7:0] I_CH1_ALERT_EN,
  input wire logic [7:0] I_CH2_FAULT,
  input wire logic       O_RES_8BIT,
  input wire logic [7:0] O_CH1_FAULT,
  input wire logic [7:0] O_CH2_ALERT_EN,
  input wire logic       O_ALERT
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  logic cor;
  assign cor = I_RD && I_ADDR == 8'h03 && I_CLEAR_ON_READ;
  a_over_sets: assert property (I_CH1_OVER[3] |=> O_CH1_FAULT[7])
    else $error("over event lost");
  a_under_sets: assert property (I_CH1_UNDER[0] |=> O_CH1_FAULT[0])
    else $error("under event lost");
  a_flags_stick: assert property (!I_WR && !cor |=>
    (O_CH1_FAULT & $past(O_CH1_FAULT)) == $past(O_CH1_FAULT))
    else $error("fault flag dropped");
  a_read_clears: assert property (cor && !I_WR &&
    I_CH1_OVER == 4'h0 && I_CH1_UNDER == 4'h0 |=> O_CH1_FAULT == 8'h00)
    else $error("fault not cleared by read");
  a_res_write: assert property (I_WR && I_ADDR == 8'h04 |=>
    O_RES_8BIT == $past(I_WDATA[7])) else $error("resolution not stored");
  a_res_keep: assert property (!(I_WR && I_ADDR == 8'h04) |=>
    $stable(O_RES_8BIT)) else $error("resolution changed");
  a_en_write: assert property (I_WR && I_ADDR == 8'h34 |=>
    O_CH2_ALERT_EN == $past(I_WDATA)) else $error("enables not stored");
  a_alert_track: assert property (1'b1 |=> O_ALERT ==
    $past(|(O_CH1_FAULT & I_CH1_ALERT_EN) || |(I_CH2_FAULT & O_CH2_ALERT_EN)))
    else $error("alert wrong");
endmodule : monitor_regs_sva
bind monitor_fault_status_regs monitor_regs_sva u_monitor_regs_sva (.*);

// ### testbench/host_model.sv
// Register host standing in for the serial engine
`timescale 1ns/1ns
module host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata
);
  initial begin
    {o_addr, o_wr, o_rd, o_wdata} = 18'h00000;
  end
  task automatic acc(input logic w, input logic [7:0] a, d,
                     output logic [7:0] q);
    @(negedge i_clk);
    {o_addr, o_wdata, o_wr, o_rd} = {a, d, w, !w};
    @(negedge i_clk);
    {o_addr, o_wdata, o_wr, o_rd} = {~a, ~d, 2'b00};
    q = i_rdata;
  endtask : acc
endmodule : host_model

// ### testbench/monitor_fault_status_regs_tb.sv
// Self-checking bench for the fault and status register slice
`timescale 1ns/1ns
module monitor_fault_status_regs_tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr, wdata, rdata, fault, ch1_en, ch2_flt, ch2_en, q, e, v, w;
  logic       wr, rd, cor, current_converters, voltage_converter, res, alert;
  logic [3:0] ovr, und;
  logic [5:0] vin;
  logic [7:0] adr [5] = '{8'h03, 8'h04, 8'h32, 8'h34, 8'h10};
  int         seed = 45;
  int         err_total = 0;
  int         cmp_count = 0;
  always #25 clk = ~clk;
  host_model u_host_model (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  monitor_fault_status_regs u_monitor_fault_status_regs (.I_CLK(clk),
    .I_RST(rst), .I_ADDR(addr), .I_WR(wr), .I_RD(rd), .I_WDATA(wdata),
    .I_CH1_OVER(ovr), .I_CH1_UNDER(und), .I_CLEAR_ON_READ(cor),
    .I_CURRENT_CONVERTERS_READY(current_converters), .I_VOLTAGE_CONVERTER_READY(voltage_converter), .I_VOLTAGE_CONVERTER_INPUT(vin),
    .I_CH1_ALERT_EN(ch1_en), .I_CH2_FAULT(ch2_flt), .O_RDATA(rdata),
    .O_RES_8BIT(res), .O_CH1_FAULT(fault), .O_CH2_ALERT_EN(ch2_en),
    .O_ALERT(alert));
  task automatic chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  function automatic logic [7:0] ev(input logic [3:0] o, u);
    for (int k = 0; k < 4; k++) ev[2*k+1 -: 2] = {o[k], u[k]};
  endfunction : ev
  task automatic pulse(input logic [3:0] o, u, input logic ia, va,
                       input logic [5:0] vi);
    @(negedge clk);
    {ovr, und, current_converters, voltage_converter, vin} = {o, u, ia, va, vi};
    @(negedge clk);
    {ovr, und, current_converters, voltage_converter, vin} = 16'h0000;
  endtask : pulse
  initial begin
    {ovr, und, cor, current_converters, voltage_converter, vin, ch1_en, ch2_flt} = 33'h0;
    e = 8'h00;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    foreach (adr[i]) begin
      u_host_model.acc(1'b0, adr[i], 8'h00, q);
      chk(q, 8'h00);
    end
    $display("test reset done");
    for (int n = 0; n < 40; n++) begin
      {v, w, ch1_en, ch2_flt} = 32'($random(seed));
      cor = 1'($random(seed));
      pulse(v[7:4], v[3:0], 1'b0, 1'b0, 6'h00);
      e = e | ev(v[7:4], v[3:0]);
      chk(fault, e);
      u_host_model.acc(1'b1, 8'h34, w, q);
      chk(ch2_en, w);
      @(negedge clk);
      chk({7'h00, alert}, {7'h00, |(e & ch1_en) | |(ch2_flt & w)});
      u_host_model.acc(1'b0, 8'h03, 8'h00, q);
      chk(q, e);
      if (cor) e = 8'h00;
      if (n % 4 == 0) begin
        u_host_model.acc(1'b1, 8'h03, w, q);
        e = w;
      end
    end
    $display("test faults done");
    foreach (adr[i]) begin
      v = 8'($random(seed));
      u_host_model.acc(1'b1, 8'h04, v, q);
      u_host_model.acc(1'b0, 8'h04, 8'h00, q);
      chk(q, v & 8'h80);
      chk({7'h00, res}, {7'h00, v[7]});
    end
    $display("test resolution done");
    for (int i = 0; i < 6; i++) begin
      pulse(4'h0, 4'h0, i[0], 1'b1, 6'(1 << i));
      u_host_model.acc(1'b1, 8'h32, 8'hFF, q);
      u_host_model.acc(1'b0, 8'h32, 8'h00, q);
      chk(q, {i[0], 1'b1, 6'(1 << i)});
      u_host_model.acc(1'b0, 8'h32, 8'h00, q);
      chk(q, 8'h00);
    end
    $display("test status done");
    // Mid-run reset with faults written to FF, resolution and enables as left by earlier tests
    u_host_model.acc(1'b1, 8'h03, 8'hFF, q);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk(fault, 8'h00);
    chk({7'h00, res}, 8'h00);
    chk(ch2_en, 8'h00);
    $display("test midrun reset done");
    test_done;
  end
endmodule : monitor_fault_status_regs_tb
